// *** hw/flash_map.svh ***
/*
 * Register offsets, field positions, keys and counts of the flash
 * sequencer. Assumes SFRs sit at 0x00xx and I/O RAM at 0x20xx of one
 * 16-bit register address space.
 */
// Behaviour
// - 32 KB program flash for code and images
// - engine code starts at base page times 1024
// - flash split into independently erasable 512-byte pages
// - write while engine busy dropped, blocked flag
// - write during pass start skips pass, flag
// - mass erase needs arm bit then 0xAA
// - mass erase only while debug port enabled
// - page erase needs page number then 0x55
// - store select routes stores to flash or RAM
// - erased bytes read 0xFF, programming clears bits
// - lock blocks all debug ops except mass erase
// - lock settable only during early boot window
// - lock removed only by reset, no erase needed
// - early boot holds debug off, flag readable
// - after early boot debug port may act
// - lock clears on reset, accepts only ones
// - lock refuses external program code reads
// - lock rejects page zero page erase; code still erases page zero for page number 64
// - lock suppresses page zero writes
// - both flags share one enable and output
// - flags clear only on written zero
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

`define FLASH_AW 15
`define PAGE_W 7
`define PAGE_SHIFT 9
`define CE_BASE_W 5
`define CE_BASE_SHIFT 10
`define PREBOOT_CYCLES 32
`define ERASED_BYTE 8'hFF

`define A_ERASE_KEY 16'h0094
`define A_MASS_ARM 16'h00B2
`define A_PAGE_SEL 16'h00B7
`define A_FLAGS 16'h00E8
`define A_IRQ_EN 16'h2007
`define A_LOCK_CFG 16'h2008
`define A_CE_BASE 16'h2009

`define B_STORE_SEL 0
`define B_MASS_ARM 1
`define B_PS_FLAG 2
`define B_WB_FLAG 3
`define B_IRQ_EN 4
`define B_LOCK 0
`define B_PREBOOT 1
`define B_SPEED 2

`define KEY_MASS 8'hAA
`define KEY_PAGE 8'h55

`endif

// *** hw/flash_pkg.sv ***
/*
 * Types shared by the flash sequencer and its boot window counter.
 * Assumes flash_map.svh is on the include path.
 */
`include "flash_map.svh"
package flash_pkg;
	typedef enum logic [1:0] {
		FC_PROG = 2'b00,
		FC_PAGE = 2'b01,
		FC_MASS = 2'b10,
		FC_NONE = 2'b11
	} flash_cmd_t;

	typedef enum logic [1:0] {
		DO_READ = 2'b00,
		DO_WRITE = 2'b01,
		DO_PAGE = 2'b10,
		DO_MASS = 2'b11
	} dbg_op_t;

	typedef struct packed {
		logic [`FLASH_AW-1:0] addr;
		logic [7:0] data;
	} store_t;

	typedef struct packed {
		flash_cmd_t cmd;
		logic [`FLASH_AW-1:0] addr;
		logic [7:0] data;
	} flash_req_t;

	typedef struct packed {
		dbg_op_t op;
		logic [`FLASH_AW-1:0] addr;
		logic [7:0] data;
	} dbg_req_t;
endpackage

// *** hw/boot_window.sv ***
/*
 * Early-boot window counter: high for the first cycles after reset.
 * Assumes the same clock, enable and reset as the flash sequencer.
 */
`timescale 1ns/1ps
`include "flash_map.svh"
module boot_window import flash_pkg::*; #(
	parameter int CYCLES = `PREBOOT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce_en,
	// window level
	output logic preboot
);
	logic [$clog2(CYCLES+1)-1:0] cnt_reg;

	// counts enabled cycles only, so a frozen core sees full window
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			preboot <= 1'b1;
		end else if (ce_en && preboot) begin
			cnt_reg <= cnt_reg + 1'b1;
			preboot <= (cnt_reg != ($bits(cnt_reg))'(CYCLES - 1));
		end
	end
endmodule

// *** hw/flash_erase_write_protect.sv ***
/*
 * Program flash sequencer: keyed erase, store routing, engine
 * collision tracking and code lock. Assumes a core SFR/I/O RAM port on
 * clk, a flash macro that reports busy on clk, and an async debug
 * enable pin.
 */
`timescale 1ns/1ps
`include "flash_map.svh"
module flash_erase_write_protect import flash_pkg::*; (
	// clock, enable and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce_en,
	// register port from the core
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// external data stores from the core
	input wire logic st_valid,
	input wire store_t st,
	output logic ram_we,
	output store_t ram_st,
	// flash macro
	output logic fl_valid,
	output flash_req_t fl_req,
	input wire logic fl_busy,
	// compute engine
	input wire logic ce_busy,
	input wire logic ce_pass_start,
	output logic ce_pass_skip,
	output logic [`FLASH_AW-1:0] ce_code_base,
	// debug emulator port
	input wire logic dbg_en_pin,
	input wire logic dbg_op_valid,
	input wire dbg_req_t dbg_req,
	output logic dbg_ack,
	output logic dbg_refuse,
	output logic dbg_hold,
	// status
	output logic flash_access_speed,
	output logic code_lock,
	output logic collision_irq
);
	logic store_sel_reg;
	logic mass_arm_reg;
	logic [`PAGE_W-1:0] page_sel_reg;
	logic page_armed_reg;
	logic wb_flag_reg;
	logic ps_flag_reg;
	logic irq_en_reg;
	logic lock_reg;
	logic speed_reg;
	logic [`CE_BASE_W-1:0] ce_base_reg;
	logic dbg_s1, dbg_s2, dbg_s3;
	logic dbg_en_reg;
	logic preboot;
	logic key_wr, e8_wr;
	logic mass_go, page_go;
	logic prog_try, prog_go, prog_blk;
	logic dbg_live, dbg_go, dbg_blk_busy;
	logic fl_go;
	flash_req_t fl_next;

	// page number of a flash byte address is zero
	function automatic logic is_page_zero(
		input logic [`FLASH_AW-1:0] a);
		return (a >> `PAGE_SHIFT) == '0;
	endfunction

	// first byte of a page; upper page bits beyond the array drop
	function automatic logic [`FLASH_AW-1:0] page_base(
		input logic [`PAGE_W-1:0] p);
		logic [`PAGE_W+`PAGE_SHIFT-1:0] w;
		w = ($bits(w))'(p) << `PAGE_SHIFT;
		return w[`FLASH_AW-1:0];
	endfunction

	boot_window #(
		.CYCLES(`PREBOOT_CYCLES)
	) u_boot (
		.clk(clk),
		.rst(rst),
		.ce_en(ce_en),
		.preboot(preboot)
	);

	// debug enable arrives from a pin: three stages, act on agreement
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dbg_s1 <= 1'b0;
			dbg_s2 <= 1'b0;
			dbg_s3 <= 1'b0;
			dbg_en_reg <= 1'b0;
		end else if (ce_en) begin
			dbg_s1 <= dbg_en_pin;
			dbg_s2 <= dbg_s1;
			dbg_s3 <= dbg_s2;
			if (dbg_s2 == dbg_s3) begin
				dbg_en_reg <= dbg_s3;
			end
		end
	end

	assign key_wr = ce_en && reg_we && reg_addr == `A_ERASE_KEY;
	assign e8_wr = ce_en && reg_we && reg_addr == `A_FLAGS;

	// mass erase: armed, correct key, debug port up, macro idle
	assign mass_go = key_wr && reg_wdata == `KEY_MASS && mass_arm_reg
		&& dbg_en_reg && !fl_busy;
	// page erase: page loaded, correct key, page number 0 refused under lock
	assign page_go = key_wr && reg_wdata == `KEY_PAGE && page_armed_reg
		&& !(lock_reg && page_sel_reg == '0)
		&& !fl_busy;

	// a store to flash while the engine fetches is dropped
	assign prog_try = ce_en && st_valid && store_sel_reg;
	assign prog_blk = ce_busy;
	assign prog_go = prog_try && !prog_blk && !fl_busy
		&& !(lock_reg && is_page_zero(st.addr));

	// debug ops are held off in early boot and without enable
	assign dbg_live = ce_en && dbg_op_valid && dbg_en_reg
		&& !preboot;
	assign dbg_blk_busy = dbg_req.op == DO_WRITE && ce_busy;

	// core requests win; debug is refused rather than queued
	always_comb begin
		dbg_go = 1'b0;
		if (dbg_live && !key_wr && !prog_try) begin
			if (lock_reg) begin
				dbg_go = dbg_req.op == DO_MASS;
			end else if (dbg_req.op == DO_READ) begin
				dbg_go = 1'b1;
			end else begin
				dbg_go = !fl_busy && !dbg_blk_busy;
			end
		end
	end

	// one flash command per cycle
	always_comb begin
		fl_go = 1'b0;
		fl_next = '{cmd: FC_NONE, addr: '0, data: `ERASED_BYTE};
		if (mass_go) begin
			fl_go = 1'b1;
			fl_next.cmd = FC_MASS;
		end else if (page_go) begin
			fl_go = 1'b1;
			fl_next.cmd = FC_PAGE;
			fl_next.addr = page_base(page_sel_reg);
		end else if (prog_go) begin
			fl_go = 1'b1;
			fl_next.cmd = FC_PROG;
			fl_next.addr = st.addr;
			fl_next.data = st.data;
		end else if (dbg_go && dbg_req.op != DO_READ) begin
			fl_go = 1'b1;
			fl_next.addr = dbg_req.addr;
			fl_next.data = dbg_req.data;
			if (dbg_req.op == DO_MASS) begin
				fl_next.cmd = FC_MASS;
			end else if (dbg_req.op == DO_PAGE) begin
				fl_next.cmd = FC_PAGE;
				fl_next.addr = page_base(
					`PAGE_W'(dbg_req.addr >> `PAGE_SHIFT));
			end else begin
				fl_next.cmd = FC_PROG;
			end
		end
	end

	// flash command strobe, one cycle per accepted request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fl_valid <= 1'b0;
			fl_req <= '{cmd: FC_NONE, addr: '0, data: `ERASED_BYTE};
		end else if (ce_en) begin
			fl_valid <= fl_go;
			if (fl_go) begin
				fl_req <= fl_next;
			end
		end
	end

	// stores that are not for flash go to data RAM unchanged
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ram_we <= 1'b0;
			ram_st <= '0;
		end else if (ce_en) begin
			ram_we <= st_valid && !store_sel_reg;
			if (st_valid && !store_sel_reg) begin
				ram_st <= st;
			end
		end
	end

	// debug answers and hold-off level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dbg_ack <= 1'b0;
			dbg_refuse <= 1'b0;
			dbg_hold <= 1'b1;
		end else if (ce_en) begin
			dbg_ack <= dbg_go;
			dbg_refuse <= dbg_op_valid && !dbg_go;
			dbg_hold <= preboot || lock_reg;
		end
	end

	// arm bits are consumed by any key write, right or wrong
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mass_arm_reg <= 1'b0;
			page_armed_reg <= 1'b0;
			page_sel_reg <= '0;
			store_sel_reg <= 1'b0;
		end else if (key_wr) begin
			mass_arm_reg <= 1'b0;
			page_armed_reg <= 1'b0;
		end else if (ce_en && reg_we && reg_addr == `A_MASS_ARM) begin
			mass_arm_reg <= reg_wdata[`B_MASS_ARM];
			store_sel_reg <= reg_wdata[`B_STORE_SEL];
		end else if (ce_en && reg_we && reg_addr == `A_PAGE_SEL) begin
			page_sel_reg <= reg_wdata[7:1];
			page_armed_reg <= 1'b1;
		end
	end

	// collision flags: hardware set beats a software clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_flag_reg <= 1'b0;
			ps_flag_reg <= 1'b0;
		end else if (ce_en) begin
			if ((prog_try && prog_blk)
				|| (dbg_live && dbg_blk_busy && !lock_reg)) begin
				wb_flag_reg <= 1'b1;
			end else if (e8_wr && !reg_wdata[`B_WB_FLAG]) begin
				wb_flag_reg <= 1'b0;
			end
			if (ce_pass_start && fl_busy) begin
				ps_flag_reg <= 1'b1;
			end else if (e8_wr && !reg_wdata[`B_PS_FLAG]) begin
				ps_flag_reg <= 1'b0;
			end
		end
	end

	// a pass that would meet a running write is dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ce_pass_skip <= 1'b0;
		end else if (ce_en) begin
			ce_pass_skip <= ce_pass_start && fl_busy;
		end
	end

	// shared enable for both collision flags onto one line
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			collision_irq <= 1'b0;
		end else if (ce_en) begin
			collision_irq <= irq_en_reg
				&& (wb_flag_reg || ps_flag_reg);
		end
	end

	// lock only takes ones, only in early boot; reset clears it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_reg <= 1'b0;
		end else if (ce_en && reg_we && reg_addr == `A_LOCK_CFG
			&& preboot && reg_wdata[`B_LOCK]) begin
			lock_reg <= 1'b1;
		end
	end

	// plain configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_en_reg <= 1'b0;
			speed_reg <= 1'b0;
			ce_base_reg <= '0;
		end else if (ce_en && reg_we) begin
			if (reg_addr == `A_IRQ_EN) begin
				irq_en_reg <= reg_wdata[`B_IRQ_EN];
			end else if (reg_addr == `A_LOCK_CFG) begin
				speed_reg <= reg_wdata[`B_SPEED];
			end else if (reg_addr == `A_CE_BASE) begin
				ce_base_reg <= reg_wdata[`CE_BASE_W-1:0];
			end
		end
	end

	// engine fetch base, 1 KB aligned inside the 32 KB array
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ce_code_base <= '0;
			flash_access_speed <= 1'b0;
			code_lock <= 1'b0;
		end else if (ce_en) begin
			ce_code_base <= `FLASH_AW'(ce_base_reg)
				<< `CE_BASE_SHIFT;
			flash_access_speed <= speed_reg;
			code_lock <= lock_reg;
		end
	end

	// registered read data; the key register reads as zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (ce_en && reg_re) begin
			if (reg_addr == `A_MASS_ARM) begin
				reg_rdata <= {6'h00, mass_arm_reg, store_sel_reg};
			end else if (reg_addr == `A_PAGE_SEL) begin
				reg_rdata <= {page_sel_reg, 1'b0};
			end else if (reg_addr == `A_FLAGS) begin
				reg_rdata <= {4'h0, wb_flag_reg, ps_flag_reg, 2'h0};
			end else if (reg_addr == `A_IRQ_EN) begin
				reg_rdata <= {3'h0, irq_en_reg, 4'h0};
			end else if (reg_addr == `A_LOCK_CFG) begin
				reg_rdata <= {5'h00, speed_reg, preboot,
					lock_reg};
			end else if (reg_addr == `A_CE_BASE) begin
				reg_rdata <= {3'h0, ce_base_reg};
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	property p_write_blocked;
		@(posedge clk) disable iff (rst)
		prog_try && ce_busy
			|=> wb_flag_reg && !(fl_valid && fl_req.cmd == FC_PROG);
	endproperty
	a_write_blocked: assert property (p_write_blocked)
		else $error("blocked flash write not flagged");

	property p_pass_skip;
		@(posedge clk) disable iff (rst)
		ce_en && ce_pass_start && fl_busy |=> ce_pass_skip
			##0 ps_flag_reg;
	endproperty
	a_pass_skip: assert property (p_pass_skip)
		else $error("pass during write not skipped");

	property p_mass_seq;
		@(posedge clk) disable iff (rst)
		key_wr && reg_wdata == `KEY_MASS && mass_arm_reg && dbg_en_reg
			&& !fl_busy |=> fl_valid && fl_req.cmd == FC_MASS;
	endproperty
	a_mass_seq: assert property (p_mass_seq)
		else $error("keyed mass erase not issued");

	property p_mass_dbg;
		@(posedge clk) disable iff (rst)
		key_wr && !dbg_en_reg && !dbg_go
			|=> !(fl_valid && fl_req.cmd == FC_MASS);
	endproperty
	a_mass_dbg: assert property (p_mass_dbg)
		else $error("mass erase without debug port");

	property p_page0_erase;
		@(posedge clk) disable iff (rst)
		key_wr && lock_reg && page_sel_reg == '0
			|=> !(fl_valid && fl_req.cmd == FC_PAGE);
	endproperty
	a_page0_erase: assert property (p_page0_erase)
		else $error("locked page zero erased");

	property p_page0_write;
		@(posedge clk) disable iff (rst)
		prog_try && lock_reg && is_page_zero(st.addr)
			|=> !(fl_valid && fl_req.cmd == FC_PROG);
	endproperty
	a_page0_write: assert property (p_page0_write)
		else $error("locked page zero written");

	property p_lock_sticky;
		@(posedge clk) disable iff (rst)
		lock_reg |=> lock_reg [*3];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock cleared without reset");

	property p_lock_window;
		@(posedge clk) disable iff (rst)
		!preboot && !lock_reg |=> !lock_reg;
	endproperty
	a_lock_window: assert property (p_lock_window)
		else $error("lock set after early boot");

	property p_dbg_locked;
		@(posedge clk) disable iff (rst)
		ce_en && dbg_op_valid && lock_reg && dbg_req.op != DO_MASS
			|=> dbg_refuse && !dbg_ack;
	endproperty
	a_dbg_locked: assert property (p_dbg_locked)
		else $error("debug op passed under lock");

	property p_flag_hold;
		@(posedge clk) disable iff (rst)
		wb_flag_reg && !(e8_wr && !reg_wdata[`B_WB_FLAG])
			|=> wb_flag_reg;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("collision flag lost");
endmodule

// *** tb/flash_macro_model.sv ***
/*
 * Flash macro model: carries out sequencer commands and stays busy 3 cycles, or 40 when slow.
 * Assumes the sequencer's clock and reset.
 */
`timescale 1ns/1ps
module flash_macro_model import flash_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// command in, busy out
	input wire logic fl_valid,
	input wire flash_req_t fl_req,
	input wire logic slow,
	output logic fl_busy
);
	logic [7:0] mem [0:32767];
	int cnt;

	// array starts erased
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
	end

	// slow stretches busy so a write can overlap an engine pass;
	// busy moves by non-blocking update so the sequencer sees no race
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end else if (fl_valid && fl_req.cmd != FC_NONE) begin
			cnt <= slow ? 40 : 3;
			case (fl_req.cmd)
				FC_PROG: mem[fl_req.addr] &= fl_req.data;
				FC_PAGE: for (int i = 0; i < 512; i++) begin
					mem[{fl_req.addr[14:9], 9'(i)}] = 8'hFF;
				end
				FC_MASS: foreach (mem[i]) mem[i] = 8'hFF;
				default: begin
				end
			endcase
		end
	end

	assign fl_busy = (cnt != 0);
endmodule

// *** tb/tb_flash_erase_write_protect.sv ***
/*
 * Self-checking bench for the flash sequencer.
 * Assumes flash_pkg, flash_map.svh and the flash model compile first.
 */
`timescale 1ns/1ps
module tb_flash_erase_write_protect import flash_pkg::*;;
	// design and model hookup
	logic clk, rst, ce_en, reg_we, reg_re, st_valid, ram_we, fl_valid;
	logic fl_busy, ce_busy, ce_pass_start, ce_pass_skip, dbg_en_pin;
	logic dbg_op_valid, dbg_ack, dbg_refuse, dbg_hold, flash_access_speed;
	logic code_lock, collision_irq, slow;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [14:0] ce_code_base;
	store_t st, ram_st;
	flash_req_t fl_req;
	dbg_req_t dbg_req;
	int n_fail, cmp_count;

	flash_erase_write_protect i_dut (.clk(clk), .rst(rst), .ce_en(ce_en),
		.reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .st_valid(st_valid),
		.st(st), .ram_we(ram_we), .ram_st(ram_st), .fl_valid(fl_valid),
		.fl_req(fl_req), .fl_busy(fl_busy), .ce_busy(ce_busy),
		.ce_pass_start(ce_pass_start), .ce_pass_skip(ce_pass_skip),
		.ce_code_base(ce_code_base), .dbg_en_pin(dbg_en_pin),
		.dbg_op_valid(dbg_op_valid), .dbg_req(dbg_req), .dbg_ack(dbg_ack),
		.dbg_refuse(dbg_refuse), .dbg_hold(dbg_hold),
		.flash_access_speed(flash_access_speed), .code_lock(code_lock),
		.collision_irq(collision_irq));
	flash_macro_model i_flash (.clk(clk), .rst(rst), .fl_valid(fl_valid),
		.fl_req(fl_req), .slow(slow), .fl_busy(fl_busy));

	// 200 MHz clock
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	// every drive lands 1 ns after a rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		cyc(1);
		reg_we = 1;
		reg_addr = a;
		reg_wdata = v;
		cyc(1);
		reg_we = 0;
	endtask

	task automatic rd(input logic [15:0] a);
		cyc(1);
		reg_re = 1;
		reg_addr = a;
		cyc(1);
		reg_re = 0;
		d = reg_rdata;
	endtask

	task automatic store(input logic [14:0] a, input logic [7:0] v);
		cyc(1);
		st_valid = 1;
		st = {a, v};
		cyc(1);
		st_valid = 0;
	endtask

	task automatic dchk(input dbg_op_t op, input logic [14:0] a,
		input logic ok);
		cyc(1);
		dbg_op_valid = 1;
		dbg_req = {op, a, 8'h00};
		cyc(1);
		dbg_op_valid = 0;
		chk({dbg_ack, dbg_refuse}, ok ? 2'h2 : 2'h1);
	endtask

	task automatic pass;
		cyc(1);
		ce_pass_start = 1;
		cyc(1);
		ce_pass_start = 0;
	endtask

	// let the macro finish before the next flash command
	task automatic drain;
		cyc(2);
		for (int i = 0; i < 100 && fl_busy !== 1'h0; i++) cyc(1);
	endtask

	task automatic fchk(input flash_cmd_t c);
		chk({fl_valid, fl_req.cmd}, {1'h1, c});
		drain();
	endtask

	task automatic do_rst;
		rst = 1;
		cyc(16);
		chk({fl_req.cmd, fl_req.data, code_lock}, {FC_NONE, 8'hFF, 1'h0});
		rst = 0;
	endtask

	task automatic t_boot;
		chk(dbg_hold, 1);
		rd(16'h2008);
		chk(d[1], 1);
		dchk(DO_READ, 15'h0000, 0);
		cyc(40);
		chk(dbg_hold, 0);
		dchk(DO_READ, 15'h0000, 1);
		wr(16'h2008, 8'h05);
		cyc(1);
		chk({code_lock, flash_access_speed}, 2'h1);
	endtask

	task automatic t_base;
		wr(16'h2009, 8'h05);
		cyc(1);
		chk(ce_code_base, 15'h1400);
		wr(16'h2009, 8'h1F);
		cyc(1);
		chk(ce_code_base, 15'h7C00);
		// a write while the clock enable is low must not land
		ce_en = 0;
		wr(16'h2009, 8'h03);
		cyc(1);
		chk(ce_code_base, 15'h7C00);
		ce_en = 1;
	endtask

	task automatic t_mass;
		wr(16'h00B2, 8'h02);
		wr(16'h0094, 8'hAA);
		fchk(FC_MASS);
		wr(16'h0094, 8'hAA);
		chk(fl_valid, 0);
		wr(16'h00B2, 8'h02);
		wr(16'h0094, 8'h12);
		chk(fl_valid, 0);
		dbg_en_pin = 0;
		cyc(8);
		wr(16'h00B2, 8'h02);
		wr(16'h0094, 8'hAA);
		chk(fl_valid, 0);
		dbg_en_pin = 1;
		cyc(8);
	endtask

	task automatic t_page;
		logic [6:0] pg [3] = '{7'h00, 7'h01, 7'h3F};
		foreach (pg[i]) begin
			wr(16'h00B7, {pg[i], 1'h0});
			wr(16'h0094, 8'h55);
			chk(fl_req.addr, {pg[i], 9'h000});
			fchk(FC_PAGE);
		end
	endtask

	// flash writes are issued with the engine idle
	task automatic t_store;
		wr(16'h00B2, 8'h00);
		store(15'h0123, 8'h5A);
		chk({ram_we, fl_valid, ram_st}, {2'h2, 15'h0123, 8'h5A});
		wr(16'h00B2, 8'h01);
		store(15'h0234, 8'h3C);
		chk({ram_we, fl_req}, {1'h0, FC_PROG, 15'h0234, 8'h3C});
		fchk(FC_PROG);
		dchk(DO_WRITE, 15'h0400, 1);
		fchk(FC_PROG);
		dchk(DO_PAGE, 15'h0400, 1);
		chk(fl_req.addr, 15'h0400);
		fchk(FC_PAGE);
	endtask

	task automatic t_collide;
		wr(16'h2007, 8'h10);
		ce_busy = 1;
		store(15'h0300, 8'h11);
		chk(fl_valid, 0);
		dchk(DO_WRITE, 15'h0300, 0);
		ce_busy = 0;
		cyc(2);
		rd(16'h00E8);
		chk({d[3:2], collision_irq}, 3'h5);
		wr(16'h00E8, 8'hFF);
		rd(16'h00E8);
		chk(d[3], 1);
		wr(16'h00E8, 8'hF7);
		rd(16'h00E8);
		chk({d[3], collision_irq}, 2'h0);
		slow = 1;
		store(15'h0301, 8'h22);
		cyc(2);
		pass();
		chk(ce_pass_skip, 1);
		rd(16'h00E8);
		chk({d[3:2], collision_irq}, 3'h3);
		wr(16'h00E8, 8'hFB);
		drain();
		slow = 0;
		pass();
		chk(ce_pass_skip, 0);
	endtask

	task automatic t_lock;
		do_rst();
		wr(16'h2008, 8'h01);
		cyc(1);
		chk(code_lock, 1);
		wr(16'h2008, 8'h00);
		cyc(40);
		chk({code_lock, dbg_hold}, 2'h3);
		dchk(DO_READ, 15'h0400, 0);
		dchk(DO_WRITE, 15'h0400, 0);
		dchk(DO_PAGE, 15'h0400, 0);
		wr(16'h00B7, 8'h00);
		wr(16'h0094, 8'h55);
		chk(fl_valid, 0);
		wr(16'h00B7, 8'h02);
		wr(16'h0094, 8'h55);
		fchk(FC_PAGE);
		wr(16'h00B2, 8'h01);
		store(15'h0005, 8'h00);
		chk(fl_valid, 0);
		store(15'h0258, 8'h00);
		fchk(FC_PROG);
		dchk(DO_MASS, 15'h0000, 1);
		fchk(FC_MASS);
		do_rst();
	endtask

	// main sequence
	initial begin
		{rst, reg_we, reg_re, st_valid, ce_busy, ce_pass_start} = '0;
		{dbg_op_valid, slow, reg_wdata, n_fail, cmp_count} = '0;
		reg_addr = 16'h0000;
		st = '0;
		dbg_req = '0;
		ce_en = 1;
		dbg_en_pin = 1;
		cyc(0);
		do_rst();
		t_boot();
		t_base();
		t_mass();
		t_page();
		t_store();
		t_collide();
		t_lock();
		finish_test();
	end

	// a hang ends the run as a mismatch
	initial begin
		#100us;
		n_fail++;
		finish_test();
	end
endmodule
